// ### rtl/temp_limit_and_ambient_regs.sv
module temp_limit_and_ambient_regs
  import temp_limit_pkg::*;
#(
  parameter int CONV_CYCLES_P = CONV_CYCLES
)
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // register port
  input wire logic [7:0] reg_ptr,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  // configuration from the config register
  input wire cfg_s cfg,
  input wire res_e resolution,
  // converter
  output logic conv_start,
  input wire logic conv_valid,
  input wire logic [12:0] conv_data,
  // status
  output logic event_active,
  output flags_s flags
);

  // ----------------------------------------
  // boundary registers
  // ----------------------------------------
  logic [10:0] lim_upper;
  logic [10:0] lim_lower;
  logic [10:0] lim_crit;
  logic [10:0] next_lim_upper;
  logic [10:0] next_lim_lower;
  logic [10:0] next_lim_crit;
  logic wr_upper;
  logic wr_lower;
  logic wr_crit;

  always_comb
  begin
    wr_upper = wr_en && reg_ptr == PTR_UPPER && !cfg.win_lock;
    wr_lower = wr_en && reg_ptr == PTR_LOWER && !cfg.win_lock;
    wr_crit = wr_en && reg_ptr == PTR_CRIT && !cfg.crit_lock;
    next_lim_upper = lim_upper;
    next_lim_lower = lim_lower;
    next_lim_crit = lim_crit;
    // only bits 12..2 are stored, the rest stays zero
    if (wr_upper)
    begin
      next_lim_upper = wr_data[LIM_MSB:LIM_LSB];
    end
    if (wr_lower)
    begin
      next_lim_lower = wr_data[LIM_MSB:LIM_LSB];
    end
    if (wr_crit)
    begin
      next_lim_crit = wr_data[LIM_MSB:LIM_LSB];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      lim_upper <= LIM_RESET;
      lim_lower <= LIM_RESET;
      lim_crit <= LIM_RESET;
    end
    else if (ce)
    begin
      lim_upper <= next_lim_upper;
      lim_lower <= next_lim_lower;
      lim_crit <= next_lim_crit;
    end
  end

  // ----------------------------------------
  // conversion timing
  // ----------------------------------------
  conv_state_e state;
  conv_state_e next_state;
  logic [23:0] cnt;
  logic [23:0] next_cnt;
  logic load;

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    conv_start = 1'b0;
    load = 1'b0;
    unique case (state)
      ST_HALT:
      begin
        if (!cfg.shutdown_select)
        begin
          next_state = ST_COUNT;
          next_cnt = '0;
        end
      end
      ST_COUNT:
      begin
        if (cfg.shutdown_select)
        begin
          next_state = ST_HALT;
        end
        else if (cnt == '0)
        begin
          conv_start = ce;
          next_state = ST_WAIT;
        end
        else
        begin
          next_cnt = cnt - 24'h00_0001;
        end
      end
      ST_WAIT:
      begin
        // a result landing during shutdown is dropped, old value kept
        if (cfg.shutdown_select)
        begin
          next_state = ST_HALT;
        end
        else if (conv_valid)
        begin
          load = 1'b1;
          next_state = ST_COUNT;
          next_cnt = 24'(CONV_CYCLES_P - 1);
        end
      end
      default:
      begin
        next_state = ST_HALT;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= ST_COUNT;
      cnt <= '0;
    end
    else if (ce)
    begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // ----------------------------------------
  // ambient register
  // ----------------------------------------
  logic [12:0] amb;
  logic [12:0] next_amb;
  logic [12:0] res_mask;

  always_comb
  begin
    unique case (resolution)
      RES_HALF: res_mask = 13'h1FF8;
      RES_QUARTER: res_mask = 13'h1FFC;
      RES_EIGHTH: res_mask = 13'h1FFE;
      RES_SIXTEENTH: res_mask = 13'h1FFF;
    endcase
    // the visible copy changes only on a whole-word load: no torn reads
    next_amb = amb;
    if (load)
    begin
      next_amb = conv_data & res_mask;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      amb <= AMB_RESET;
    end
    else if (ce)
    begin
      amb <= next_amb;
    end
  end

  // ----------------------------------------
  // comparison flags and event
  // ----------------------------------------
  flags_s cmp_flags;
  flags_s next_flags;
  logic next_event;
  logic reeval;
  logic next_reeval;

  always_comb
  begin
    // no config bit enters here, so flags stay true while event is off
    cmp_flags.crit = $signed(amb) >= $signed({lim_crit, 2'b00});
    cmp_flags.upper = $signed(amb) > $signed({lim_upper, 2'b00});
    cmp_flags.lower = $signed(amb) < $signed({lim_lower, 2'b00});
    // flags move only after a load or boundary write: ambient reads zero till then
    next_reeval = load || wr_upper || wr_lower || wr_crit;
    next_flags = reeval ? cmp_flags : flags;
    next_event = 1'b0;
    if (cfg.event_enable && !cfg.shutdown_select)
    begin
      next_event = cfg.crit_only ? next_flags.crit : (|next_flags);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      flags <= '0;
      event_active <= 1'b0;
      reeval <= 1'b0;
    end
    else if (ce)
    begin
      flags <= next_flags;
      event_active <= next_event;
      reeval <= next_reeval;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [15:0] next_rd;

  always_comb
  begin
    next_rd = rd_data;
    if (rd_en)
    begin
      unique case (reg_ptr)
        PTR_UPPER: next_rd = {3'h0, lim_upper, 2'h0};
        PTR_LOWER: next_rd = {3'h0, lim_lower, 2'h0};
        PTR_CRIT: next_rd = {3'h0, lim_crit, 2'h0};
        PTR_AMBIENT: next_rd = {flags.crit, flags.upper, flags.lower, amb};
        default: next_rd = RD_RESET;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_data <= RD_RESET;
    end
    else if (ce)
    begin
      rd_data <= next_rd;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_window_lock: assert property (
    ce && wr_en && cfg.win_lock && (reg_ptr == PTR_UPPER || reg_ptr == PTR_LOWER)
    |=> $stable(lim_upper) && $stable(lim_lower))
    else $error("window lock let a boundary write through");
  chk_crit_lock: assert property (
    ce && wr_en && cfg.crit_lock && reg_ptr == PTR_CRIT |=> $stable(lim_crit))
    else $error("critical lock let a write through");
  chk_upper_write: assert property (
    ce && wr_en && !cfg.win_lock && reg_ptr == PTR_UPPER
    |=> lim_upper == $past(wr_data[LIM_MSB:LIM_LSB]))
    else $error("upper boundary write lost");
  chk_ambient_ro: assert property (
    ce && wr_en && reg_ptr == PTR_AMBIENT && !load |=> $stable(amb))
    else $error("write changed ambient register");
  chk_rd_high_zero: assert property (
    ce && rd_en && (reg_ptr == PTR_UPPER || reg_ptr == PTR_CRIT)
    |=> rd_data[15:13] == 3'h0)
    else $error("boundary read high bits not zero");
  chk_rd_low_zero: assert property (
    ce && rd_en && reg_ptr == PTR_LOWER |=> rd_data[1:0] == 2'h0)
    else $error("boundary read low bits not zero");
  chk_load_whole: assert property (
    ce && load && resolution == RES_QUARTER
    |=> amb == ($past(conv_data) & 13'h1FFC) && amb[1:0] == 2'h0)
    else $error("conversion word not loaded whole");
  chk_shutdown_hold: assert property (
    cfg.shutdown_select ##1 cfg.shutdown_select |-> $stable(amb))
    else $error("ambient changed in shutdown");
  chk_crit_flag: assert property (
    ce && reeval ##1 ce |-> flags.crit == ($signed($past(amb))
      >= $signed({$past(lim_crit), 2'b00})))
    else $error("critical flag wrong");
  chk_upper_flag: assert property (
    ce ##1 ce && $past(amb) == {$past(lim_upper), 2'b00} |-> !flags.upper)
    else $error("upper flag set on equality");
  chk_lower_flag: assert property (
    ce && $signed(amb) < $signed({lim_lower, 2'b00}) |=> flags.lower)
    else $error("lower flag missed");
  chk_event_off: assert property (
    ce && (cfg.shutdown_select || !cfg.event_enable) |=> !event_active)
    else $error("event asserted while disabled");
  cov_load: cover property (ce && load);
  cov_lock_refused: cover property (ce && wr_en && cfg.crit_lock && reg_ptr == PTR_CRIT);
  cov_crit_event: cover property (event_active && flags.crit);
  cov_resume: cover property (state == ST_HALT ##1 state == ST_COUNT);

endmodule

// ### rtl/temp_limit_pkg.sv
package temp_limit_pkg;

  // ----------------------------------------
  // register pointer decode
  // ----------------------------------------
  localparam logic [7:0] PTR_UPPER = 8'h02;
  localparam logic [7:0] PTR_LOWER = 8'h03;
  localparam logic [7:0] PTR_CRIT = 8'h04;
  localparam logic [7:0] PTR_AMBIENT = 8'h05;

  // ----------------------------------------
  // field layout and reset values
  // ----------------------------------------
  localparam int LIM_MSB = 12;
  localparam int LIM_LSB = 2;
  localparam int FLAG_CRIT_BIT = 15;
  localparam int FLAG_UPPER_BIT = 14;
  localparam int FLAG_LOWER_BIT = 13;
  localparam int AMB_MSB = 12;
  localparam logic [10:0] LIM_RESET = 11'h000;
  localparam logic [12:0] AMB_RESET = 13'h0000;
  localparam logic [15:0] RD_RESET = 16'h0000;

  // ----------------------------------------
  // conversion period timing
  // ----------------------------------------
  localparam int CONV_PERIOD_MS = 46;
  localparam int CLK_MHZ = 250;
  localparam int CONV_CYCLES = CONV_PERIOD_MS * CLK_MHZ * 1000;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    RES_HALF = 2'h0,
    RES_QUARTER = 2'h1,
    RES_EIGHTH = 2'h2,
    RES_SIXTEENTH = 2'h3
  } res_e;

  typedef enum logic [2:0] {
    ST_HALT = 3'h1,
    ST_COUNT = 3'h2,
    ST_WAIT = 3'h4
  } conv_state_e;

  typedef struct packed {
    logic shutdown_select;
    logic win_lock;
    logic crit_lock;
    logic event_enable;
    logic crit_only;
  } cfg_s;

  typedef struct packed {
    logic crit;
    logic upper;
    logic lower;
  } flags_s;

endpackage

// ### dv/conv_model.sv
// ----------------------------------------
// converter stand-in: answers each start taken while idle after a delay
// ----------------------------------------
module conv_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // converter handshake
  input wire logic conv_start,
  output logic conv_valid,
  output logic [12:0] conv_data,
  // scene control
  input wire logic [12:0] temp,
  input wire logic [7:0] delay
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  logic [7:0] cnt;
  // data toggles outside the valid pulse so a stale word never passes
  always_ff @(posedge clk)
  begin
    conv_valid <= 1'b0;
    conv_data <= ~conv_data;
    if (!rst_n)
    begin
      busy <= 1'b0;
      cnt <= 8'h00;
      conv_data <= 13'h0aaa;
    end
    else if (conv_start && !busy)
    begin
      busy <= 1'b1;
      cnt <= delay;
    end
    else if (busy && cnt == 8'h00)
    begin
      busy <= 1'b0;
      conv_valid <= 1'b1;
      conv_data <= temp;
    end
    else if (busy)
    begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule

// ### dv/test_temp_limit_and_ambient_regs.sv
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module test_temp_limit_and_ambient_regs
  import temp_limit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // stimulus and wiring
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] up;
    logic [15:0] lo;
    logic [15:0] cr;
    logic [2:0] fl;
  } row_s;
  row_s rows [3] = '{
    '{16'h0190, 16'h0190, 16'h0190, 3'b100},
    '{16'h018c, 16'h0194, 16'h0194, 3'b011},
    '{16'h1ffc, 16'h1f00, 16'h0ffc, 3'b010}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic ce = 1'b1;
  logic [31:0] host_deg;
  logic [7:0] reg_ptr = 8'h00;
  logic [15:0] wr_data = 16'h0000;
  logic [15:0] rd_data;
  cfg_s cfg = '0;
  res_e resolution = RES_QUARTER;
  logic conv_start;
  logic conv_valid;
  logic [12:0] conv_data;
  logic [12:0] temp = 13'h0193;
  logic event_active;
  flags_s flags;
  int fail_count = 0;
  int checks_done = 0;

  always #2 clk = ~clk;

  temp_limit_and_ambient_regs #(.CONV_CYCLES_P(40)) dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .reg_ptr(reg_ptr), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data),
    .cfg(cfg), .resolution(resolution), .conv_start(conv_start), .conv_valid(conv_valid),
    .conv_data(conv_data), .event_active(event_active), .flags(flags));

  conv_model partner (.clk(clk), .rst_n(rst_n), .conv_start(conv_start),
    .conv_valid(conv_valid), .conv_data(conv_data), .temp(temp), .delay(8'h14));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    reg_ptr <= p;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] p, input logic [15:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    reg_ptr <= p;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    `CHK("rd_data", e, rd_data)
  endtask

  // bounded: a converter that never answers ends the run
  task automatic wait_valid();
    int i;
    for (i = 0; i < 200 && conv_valid !== 1'b1; i++)
      @(negedge clk);
    if (i == 200)
    begin
      fail_count++;
      final_report();
    end
    else
    begin
      @(posedge clk);
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    cfg.event_enable <= 1'b1;
    @(negedge clk);
    `CHK("flags", 3'b000, flags)
    for (int p = 2; p < 6; p++) rd(8'(p), 16'h0000);
    wait_valid();
    repeat (3) @(posedge clk);
    foreach (rows[i])
    begin
      wr(PTR_UPPER, rows[i].up);
      wr(PTR_LOWER, rows[i].lo);
      wr(PTR_CRIT, rows[i].cr);
      repeat (2) @(posedge clk);
      @(negedge clk);
      `CHK("event", |rows[i].fl, event_active)
      rd(PTR_AMBIENT, {rows[i].fl, 13'h0190});
    end
    @(posedge clk);
    cfg.crit_only <= 1'b1;
    repeat (2) @(negedge clk);
    `CHK("event", 1'b0, event_active)
    @(posedge clk);
    cfg.crit_only <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK("event", 1'b1, event_active)
    @(posedge clk);
    cfg.event_enable <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK("event", 1'b0, event_active)
    `CHK("flags", 3'b010, flags)
    wait_valid();
    cfg.shutdown_select <= 1'b1;
    temp <= 13'h1ff7;
    resolution <= RES_HALF;
    repeat (60)
    begin
      @(negedge clk);
      `CHK("conv_start", 1'b0, conv_start)
    end
    rd(PTR_AMBIENT, {3'b010, 13'h0190});
    @(posedge clk);
    cfg.shutdown_select <= 1'b0;
    wait_valid();
    repeat (3) @(posedge clk);
    rd(PTR_AMBIENT, 16'h1ff0);
    // host view: high nibble up four bits, low byte down four, minus 256 if negative
    host_deg = 32'(rd_data[11:8]) * 16 + 32'(rd_data[7:0]) / 16 - (rd_data[12] ? 256 : 0);
    `CHK("degrees", 32'hffff_ffff, host_deg)
    wr(PTR_UPPER, 16'hffff);
    rd(PTR_UPPER, 16'h1ffc);
    wr(PTR_CRIT, 16'he003);
    rd(PTR_CRIT, 16'h0000);
    wr(PTR_AMBIENT, 16'hffff);
    rd(PTR_AMBIENT, 16'h1ff0);
    wr(8'h06, 16'h1234);
    rd(8'h06, 16'h0000);
    // a write offered while the enable is low must not land
    @(posedge clk);
    ce <= 1'b0;
    wr(PTR_LOWER, 16'h0040);
    ce <= 1'b1;
    rd(PTR_LOWER, 16'h1f00);
    @(posedge clk);
    cfg.win_lock <= 1'b1;
    cfg.crit_lock <= 1'b1;
    wr(PTR_UPPER, 16'h0100);
    wr(PTR_LOWER, 16'h0100);
    wr(PTR_CRIT, 16'h0100);
    rd(PTR_UPPER, 16'h1ffc);
    rd(PTR_LOWER, 16'h1f00);
    rd(PTR_CRIT, 16'h0000);
    final_report();
  end
endmodule
